// File: src/iom_io_map.sv
`include "iom_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module iom_io_map (
  input  wire logic              clk_sys,          // core clock
  input  wire logic              reset_n,          // sync reset, low
  input  wire iom_pkg::iom_acc_t acc,              // core access
  output iom_pkg::iom_rsp_t      rsp,              // answer, next cycle
  output iom_pkg::iom_wr_t       wr_notice,        // write seen by peripherals
  input  wire logic [7:0]        pin_a_level,      // port a pin levels
  input  wire logic [7:0]        pin_b_level,      // port b pin levels
  input  wire logic [1:0]        pin_d_level,      // port d pin levels
  input  wire logic [11:0]       conv_result,      // voltage converter result
  input  wire logic [2:0]        timer0_event,     // timer0 flag set pulses
  input  wire logic [1:0]        timer1_event,     // timer1 flag set pulses
  input  wire logic [1:0]        pin_change_event, // pin change set pulses
  output logic [7:0]             port_a_drive,     // port a pin out value
  output logic [7:0]             port_a_oe,        // port a output enable
  output logic [7:0]             port_b_drive,     // port b pin out value
  output logic [7:0]             port_b_oe,        // port b output enable
  output logic                   port_c_oe,        // open drain, pulls low
  output logic [1:0]             port_d_drive,     // port d pin out value
  output logic [1:0]             port_d_oe         // port d output enable
);

  // one cell per data-space location of the map
  localparam int N_LOC = 224;  // data-space 20..FF

  // build one decode entry
  function automatic iom_pkg::iom_info_t mk(
    input logic       ro,
    input logic [7:0] wm,
    input logic [7:0] w1
  );
    iom_pkg::iom_info_t f;
    f.ro    = ro;
    f.wmask = wm;
    f.w1c   = w1;
    return f;
  endfunction

  // ro: live inputs, wmask: bits that store, w1c: flags
  // reserved bits never store, so software zeros cost nothing
  // per-location writable and flag bits; absent means reserved
  function automatic iom_pkg::iom_info_t decode(input logic [7:0] a);
    iom_pkg::iom_info_t f;
    f = mk(1'b0, 8'h00, 8'h00);  // reserved: reads zero, stores nothing
    case (a)
      // port a: live pins, direction, output
      // pin bytes have no storage behind them
      `IOM_PORT_A_INPUT:       f = mk(1'b1, 8'h00, 8'h00);
      `IOM_PORT_A_DIRECTION:   f = mk(1'b0, 8'hFF, 8'h00);
      `IOM_PORT_A_OUTPUT:      f = mk(1'b0, 8'hFF, 8'h00);

      // port b, laid out as port a
      `IOM_PORT_B_INPUT:       f = mk(1'b1, 8'h00, 8'h00);
      `IOM_PORT_B_DIRECTION:   f = mk(1'b0, 8'hFF, 8'h00);
      `IOM_PORT_B_OUTPUT:      f = mk(1'b0, 8'hFF, 8'h00);

      // port c: one open drain bit
      // no pin byte, since it only sinks
      `IOM_PORT_C_OUTPUT:      f = mk(1'b0, 8'h01, 8'h00);

      // port d: two pins only
      // upper six bits are reserved
      `IOM_PORT_D_INPUT:       f = mk(1'b1, 8'h00, 8'h00);
      `IOM_PORT_D_DIRECTION:   f = mk(1'b0, 8'h03, 8'h00);
      `IOM_PORT_D_OUTPUT:      f = mk(1'b0, 8'h03, 8'h00);

      // status flags: a written one clears
      // events win over a clear in one cycle
      `IOM_TIMER0_FLAGS:       f = mk(1'b0, 8'h00, 8'h07);
      `IOM_TIMER1_FLAGS:       f = mk(1'b0, 8'h00, 8'h03);
      `IOM_PIN_CHANGE_FLAGS:   f = mk(1'b0, 8'h00, 8'h03);

      // eeprom control, data and address
      // mixed bytes act as plain read/write
      `IOM_EEPROM_CONTROL:     f = mk(1'b0, 8'h3F, 8'h00);
      `IOM_EEPROM_DATA:        f = mk(1'b0, 8'hFF, 8'h00);
      `IOM_EEPROM_ADDR_LOW:    f = mk(1'b0, 8'hFF, 8'h00);
      `IOM_EEPROM_ADDR_HIGH:   f = mk(1'b0, 8'h01, 8'h00);

      // timer control, count and compares
      // the timer itself lives elsewhere
      `IOM_GENERAL_TIMER_CTRL: f = mk(1'b0, 8'h83, 8'h00);
      `IOM_TIMER0_CONTROL_A:   f = mk(1'b0, 8'hF3, 8'h00);
      `IOM_TIMER0_CONTROL_B:   f = mk(1'b0, 8'hCF, 8'h00);
      `IOM_TIMER0_COUNT:       f = mk(1'b0, 8'hFF, 8'h00);
      `IOM_TIMER0_COMPARE_A:   f = mk(1'b0, 8'hFF, 8'h00);
      `IOM_TIMER0_COMPARE_B:   f = mk(1'b0, 8'hFF, 8'h00);

      // scratch bytes and debug channel
      `IOM_SCRATCH_BYTE_ONE:   f = mk(1'b0, 8'hFF, 8'h00);
      `IOM_SCRATCH_BYTE_TWO:   f = mk(1'b0, 8'hFF, 8'h00);
      `IOM_DEBUG_CHANNEL_BYTE: f = mk(1'b0, 8'hFF, 8'h00);

      // sleep, reset cause, core control
      `IOM_SLEEP_CONTROL:      f = mk(1'b0, 8'h0F, 8'h00);
      `IOM_RESET_CAUSE_STATUS: f = mk(1'b0, 8'h1F, 8'h00);
      `IOM_CORE_CONTROL:       f = mk(1'b0, 8'h93, 8'h00);
      `IOM_SELF_PROGRAM_CTRL:  f = mk(1'b0, 8'hFF, 8'h00);

      // stack pointer and condition flags
      `IOM_STACK_POINTER_LOW:  f = mk(1'b0, 8'hFF, 8'h00);
      `IOM_STACK_POINTER_HIGH: f = mk(1'b0, 8'hFF, 8'h00);
      `IOM_CORE_COND_FLAGS:    f = mk(1'b0, 8'hFF, 8'h00);

      // extended window from here on
      // port and bit ops never reach it
      `IOM_WATCHDOG_CONTROL:   f = mk(1'b0, 8'hFF, 8'h00);
      `IOM_WAKEUP_TIMER_CTRL:  f = mk(1'b0, 8'hFF, 8'h00);
      `IOM_POWER_REDUCTION:    f = mk(1'b0, 8'h0F, 8'h00);
      `IOM_FAST_OSC_TRIM:      f = mk(1'b0, 8'hFF, 8'h00);

      // interrupt sense, enables, masks
      // only named enable bits store
      `IOM_PIN_CHANGE_ENABLE:  f = mk(1'b0, 8'h03, 8'h00);
      `IOM_EXT_IRQ_SENSE_CTRL: f = mk(1'b0, 8'hFF, 8'h00);
      `IOM_PIN_CHANGE_MASK_LO: f = mk(1'b0, 8'hFF, 8'h00);
      `IOM_PIN_CHANGE_MASK_HI: f = mk(1'b0, 8'hFF, 8'h00);
      `IOM_TIMER0_IRQ_MASK:    f = mk(1'b0, 8'h07, 8'h00);
      `IOM_TIMER1_IRQ_MASK:    f = mk(1'b0, 8'h03, 8'h00);

      // converter result and controls
      // the result bytes are live inputs
      `IOM_VCONV_RESULT_LOW:   f = mk(1'b1, 8'h00, 8'h00);
      `IOM_VCONV_RESULT_HIGH:  f = mk(1'b1, 8'h00, 8'h00);
      `IOM_VCONV_CONTROL:      f = mk(1'b0, 8'h0F, 8'h00);
      `IOM_VCONV_CHANNEL_SEL:  f = mk(1'b0, 8'h0F, 8'h00);
      `IOM_DIGITAL_IN_DISABLE: f = mk(1'b0, 8'h0F, 8'h00);

      // anything else is reserved
      default:                 f = mk(1'b0, 8'h00, 8'h00);
    endcase
    return f;
  endfunction

  // live value of a read-only location
  function automatic logic [7:0] ro_value(
    input logic [7:0]  a,
    input logic [7:0]  pa,
    input logic [7:0]  pb,
    input logic [1:0]  pd,
    input logic [11:0] cr
  );
    logic [7:0] v;
    v = 8'h00;
    case (a)
      // pins read live each cycle
      `IOM_PORT_A_INPUT:      v = pa;
      `IOM_PORT_B_INPUT:      v = pb;
      `IOM_PORT_D_INPUT:      v = {6'h00, pd};
      // result split over two bytes
      `IOM_VCONV_RESULT_LOW:  v = cr[7:0];
      `IOM_VCONV_RESULT_HIGH: v = {4'h0, cr[11:8]};
      default:                v = 8'h00;
    endcase
    return v;
  endfunction

  // an event that is held sets its flag every cycle
  // hardware flag set pulses per location
  function automatic logic [7:0] ev_value(
    input logic [7:0] a,
    input logic [2:0] t0,
    input logic [1:0] t1,
    input logic [1:0] pc
  );
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `IOM_TIMER0_FLAGS:     v = {5'h00, t0};
      `IOM_TIMER1_FLAGS:     v = {6'h00, t1};
      `IOM_PIN_CHANGE_FLAGS: v = {6'h00, pc};
      default:               v = 8'h00;
    endcase
    return v;
  endfunction

  // the op alone picks how the address is read
  // access classification
  wire logic is_port_ld;
  wire logic is_port_st;
  wire logic is_bit_set;
  wire logic is_bit_clr;
  wire logic is_skip1;
  wire logic is_skip0;
  wire logic is_mem_rd;
  wire logic is_mem_wr;
  assign is_port_ld = acc.op == iom_pkg::OP_PORT_LOAD;
  assign is_port_st = acc.op == iom_pkg::OP_PORT_STORE;
  assign is_bit_set = acc.op == iom_pkg::OP_BIT_SET;
  assign is_bit_clr = acc.op == iom_pkg::OP_BIT_CLEAR;
  assign is_skip1   = acc.op == iom_pkg::OP_SKIP_ONE;
  assign is_skip0   = acc.op == iom_pkg::OP_SKIP_ZERO;
  assign is_mem_rd  = acc.op == iom_pkg::OP_MEM_READ;
  assign is_mem_wr  = acc.op == iom_pkg::OP_MEM_WRITE;

  // op families
  wire logic is_port;
  wire logic is_bitop;
  wire logic is_skip;
  wire logic is_mem;
  assign is_port  = is_port_ld | is_port_st;
  assign is_bitop = is_bit_set | is_bit_clr;
  assign is_skip  = is_skip1 | is_skip0;
  assign is_mem   = is_mem_rd | is_mem_wr;

  // a refused access still answers, so the core never stalls
  // window checks; the short port address never reaches the extended area
  wire logic port_ok;
  wire logic low_ok;
  wire logic mem_ok;
  wire logic legal;
  assign port_ok = acc.addr <= `IOM_PORT_LAST;
  assign low_ok  = acc.addr <= `IOM_BIT_LAST;
  assign mem_ok  = acc.addr >= `IOM_IO_TO_DATA;
  assign legal   = acc.valid & ((is_port & port_ok)
                 | ((is_bitop | is_skip) & low_ok)
                 | (is_mem & mem_ok));

  // port and bit ops add the offset; memory ops carry it
  // every window lands on one data-space address
  wire logic [7:0] daddr;
  assign daddr = is_mem ? acc.addr
               : 8'(acc.addr + `IOM_IO_TO_DATA);

  wire logic [7:0] lidx;
  assign lidx = 8'(daddr - `IOM_IO_TO_DATA);

  // storage and per-location read values
  logic [7:0] loc_q   [N_LOC];
  logic [7:0] loc_rd  [N_LOC];

  // a port or bit op near the top of its field wraps past the last
  // cell; it is refused, and reads zero instead of an unknown
  wire logic in_map;
  assign in_map = lidx < 8'(N_LOC);

  // current byte at the addressed location
  wire logic [7:0] cur;
  assign cur = (in_map & (mem_ok | ~is_mem)) ? loc_rd[lidx] : 8'h00;

  // hazard: a bit op on a flag byte clears every set flag except the one a bit clear selects
  // bit ops rewrite the full byte; flags read as one go back as one
  wire logic [7:0] bit_one;
  wire logic [7:0] rmw_val;
  assign bit_one = 8'(8'h01 << acc.bit_sel);
  assign rmw_val = is_bit_set ? (cur | bit_one)
                 : (cur & ~bit_one);

  wire logic       do_write;
  wire logic [7:0] wval;
  assign do_write = legal & (is_port_st | is_mem_wr | is_bitop);
  assign wval     = is_bitop ? rmw_val : acc.wdata;

  // one storage cell per data-space location
  genvar gi;
  generate
    for (gi = 0; gi < N_LOC; gi++) begin : g_loc
      localparam logic [7:0] LA = 8'(gi + 32);
      localparam iom_pkg::iom_info_t INF = decode(LA);
      wire logic       hit;
      wire logic [7:0] evt;
      wire logic [7:0] next_q;
      assign hit = do_write & (lidx == 8'(gi));
      assign evt = ev_value(LA, timer0_event, timer1_event,
                            pin_change_event) & INF.w1c;
      // reserved bits drop the written value
      // a flag event in the clearing cycle wins over the clear
      assign next_q = (hit ? ((wval & INF.wmask)
                             | (loc_q[gi] & INF.w1c & ~wval))
                           : loc_q[gi]) | evt;
      // a register for every location; bits that cannot store are forced to zero
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          loc_q[gi] <= `IOM_RESET_VALUE;
        end else begin
          loc_q[gi] <= next_q & (INF.wmask | INF.w1c);
        end
      end
      // stored bytes are masked again on the way out
      // read-only bytes show live inputs, reserved read zero
      assign loc_rd[gi] = INF.ro
                        ? ro_value(LA, pin_a_level, pin_b_level,
                                   pin_d_level, conv_result)
                        : (loc_q[gi] & (INF.wmask | INF.w1c));
    end
  endgenerate

  // a skip test never changes the byte it looks at
  // answer fields, registered
  wire logic       want_data;
  wire logic       bit_val;
  wire logic       skip_now;
  assign want_data = legal & (is_port_ld | is_mem_rd);
  assign bit_val   = cur[acc.bit_sel];
  assign skip_now  = legal & is_skip
                   & (bit_val == is_skip1);

  // next answer; refusal marks bad windows, data only for loads
  wire logic       next_done;
  wire logic       next_refused;
  wire logic [7:0] next_rdata;
  assign next_done    = acc.valid;
  assign next_refused = acc.valid & ~legal;
  assign next_rdata   = want_data ? cur : 8'h00;

  // answer one cycle after the access; the core never waits longer
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rsp <= '0;
    end else begin
      rsp.done    <= next_done;
      rsp.refused <= next_refused;
      rsp.skip    <= skip_now;
      rsp.rdata   <= next_rdata;
    end
  end

  // notice data rests at zero between writes, so a refused
  // bit op never shows a rewritten byte that did not land
  wire logic [7:0] next_wr_data;
  assign next_wr_data = do_write ? wval : 8'h00;

  // peripherals see every accepted write, including reserved ones
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_notice <= '0;
    end else begin
      wr_notice.valid <= do_write;
      wr_notice.addr  <= daddr;
      wr_notice.data  <= next_wr_data;
    end
  end

  // pin drivers straight from stored registers
  localparam logic [7:0] IX_AO = 8'(`IOM_PORT_A_OUTPUT - `IOM_IO_TO_DATA);
  localparam logic [7:0] IX_AD = 8'(`IOM_PORT_A_DIRECTION - `IOM_IO_TO_DATA);
  localparam logic [7:0] IX_BO = 8'(`IOM_PORT_B_OUTPUT - `IOM_IO_TO_DATA);
  localparam logic [7:0] IX_BD = 8'(`IOM_PORT_B_DIRECTION - `IOM_IO_TO_DATA);
  localparam logic [7:0] IX_CO = 8'(`IOM_PORT_C_OUTPUT - `IOM_IO_TO_DATA);
  localparam logic [7:0] IX_DO = 8'(`IOM_PORT_D_OUTPUT - `IOM_IO_TO_DATA);
  localparam logic [7:0] IX_DD = 8'(`IOM_PORT_D_DIRECTION - `IOM_IO_TO_DATA);

  // a direction bit of one lets the pin drive
  // open drain port c only ever sinks, so its level stays low
  assign port_a_drive = loc_q[IX_AO];
  assign port_a_oe    = loc_q[IX_AD];
  assign port_b_drive = loc_q[IX_BO];
  assign port_b_oe    = loc_q[IX_BD];
  assign port_c_oe    = loc_q[IX_CO][0];
  assign port_d_drive = loc_q[IX_DO][1:0];
  assign port_d_oe    = loc_q[IX_DD][1:0];

endmodule

`default_nettype wire

// File: src/iom_defines.svh
`ifndef IOM_DEFINES_SVH
`define IOM_DEFINES_SVH

// address windows, in data-space and I/O terms
`define IOM_IO_TO_DATA     8'h20
`define IOM_BIT_LAST       8'h1F
`define IOM_PORT_LAST      8'h3F
`define IOM_EXT_FIRST      8'h60
`define IOM_EXT_LAST       8'hFF
`define IOM_RESET_VALUE    8'h00

// register data-space addresses
`define IOM_PORT_A_INPUT        8'h20
`define IOM_PORT_A_DIRECTION    8'h21
`define IOM_PORT_A_OUTPUT       8'h22
`define IOM_PORT_B_INPUT        8'h23
`define IOM_PORT_B_DIRECTION    8'h24
`define IOM_PORT_B_OUTPUT       8'h25
`define IOM_PORT_C_OUTPUT       8'h28
`define IOM_PORT_D_INPUT        8'h29
`define IOM_PORT_D_DIRECTION    8'h2A
`define IOM_PORT_D_OUTPUT       8'h2B
`define IOM_TIMER0_FLAGS        8'h35
`define IOM_TIMER1_FLAGS        8'h36
`define IOM_PIN_CHANGE_FLAGS    8'h3B
`define IOM_EEPROM_CONTROL      8'h3F
`define IOM_EEPROM_DATA         8'h40
`define IOM_EEPROM_ADDR_LOW     8'h41
`define IOM_EEPROM_ADDR_HIGH    8'h42
`define IOM_GENERAL_TIMER_CTRL  8'h43
`define IOM_TIMER0_CONTROL_A    8'h44
`define IOM_TIMER0_CONTROL_B    8'h45
`define IOM_TIMER0_COUNT        8'h46
`define IOM_TIMER0_COMPARE_A    8'h47
`define IOM_TIMER0_COMPARE_B    8'h48
`define IOM_SCRATCH_BYTE_ONE    8'h4A
`define IOM_SCRATCH_BYTE_TWO    8'h4B
`define IOM_DEBUG_CHANNEL_BYTE  8'h51
`define IOM_SLEEP_CONTROL       8'h53
`define IOM_RESET_CAUSE_STATUS  8'h54
`define IOM_CORE_CONTROL        8'h55
`define IOM_SELF_PROGRAM_CTRL   8'h57
`define IOM_STACK_POINTER_LOW   8'h5D
`define IOM_STACK_POINTER_HIGH  8'h5E
`define IOM_CORE_COND_FLAGS     8'h5F
`define IOM_WATCHDOG_CONTROL    8'h60
`define IOM_WAKEUP_TIMER_CTRL   8'h62
`define IOM_POWER_REDUCTION     8'h64
`define IOM_FAST_OSC_TRIM       8'h66
`define IOM_PIN_CHANGE_ENABLE   8'h68
`define IOM_EXT_IRQ_SENSE_CTRL  8'h69
`define IOM_PIN_CHANGE_MASK_LO  8'h6B
`define IOM_PIN_CHANGE_MASK_HI  8'h6C
`define IOM_TIMER0_IRQ_MASK     8'h6E
`define IOM_TIMER1_IRQ_MASK     8'h6F
`define IOM_VCONV_RESULT_LOW    8'h78
`define IOM_VCONV_RESULT_HIGH   8'h79
`define IOM_VCONV_CONTROL       8'h7A
`define IOM_VCONV_CHANNEL_SEL   8'h7C
`define IOM_DIGITAL_IN_DISABLE  8'h7E

`endif

// File: src/iom_pkg.sv
package iom_pkg;

  // core access kinds
  typedef enum logic [2:0] {
    OP_PORT_LOAD,
    OP_PORT_STORE,
    OP_BIT_SET,
    OP_BIT_CLEAR,
    OP_SKIP_ONE,
    OP_SKIP_ZERO,
    OP_MEM_READ,
    OP_MEM_WRITE
  } iom_op_t;

  typedef struct packed {
    logic       valid;
    iom_op_t    op;
    logic [7:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } iom_acc_t;

  typedef struct packed {
    logic       done;
    logic       refused;
    logic       skip;
    logic [7:0] rdata;
  } iom_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
  } iom_wr_t;

  typedef struct packed {
    logic       ro;
    logic [7:0] wmask;
    logic [7:0] w1c;
  } iom_info_t;

endpackage

// File: test/iom_core_model.sv
`timescale 1ns/10ps
`default_nettype none

module iom_core_model (
  input  wire logic              clk_sys, // core clock
  output iom_pkg::iom_acc_t      acc,     // access to the map
  input  wire iom_pkg::iom_rsp_t rsp      // answer from the map
);
  // one access at a time, held from one edge to the taking edge
  // op, address and data pass as given; the bench picks them
  task automatic go(input iom_pkg::iom_op_t op, input logic [7:0] a,
                    input logic [2:0] b, input logic [7:0] d,
                    output iom_pkg::iom_rsp_t r, output logic ok);
    int n;
    @(posedge clk_sys);
    acc <= '{1'b1, op, a, b, d};
    @(posedge clk_sys);
    // valid drops and address and data are inverted, so stale values never look valid
    acc <= '{1'b0, op, ~a, b, ~d};
    ok = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      ok = (rsp.done === 1'b1);
      r  = rsp;
      if (!ok) @(posedge clk_sys);
    end
  endtask

  initial acc = '0;
endmodule

`default_nettype wire

// File: test/iom_io_map_chk.sv
`timescale 1ns/10ps
`default_nettype none

module iom_io_map_chk (
  input wire logic              clk_sys,     // core clock
  input wire logic              reset_n,     // sync reset, low
  input wire iom_pkg::iom_acc_t acc,         // core access
  input wire iom_pkg::iom_rsp_t rsp,         // answer
  input wire iom_pkg::iom_wr_t  wr_notice,   // write notice
  input wire logic [7:0]        pin_a_level, // port a pins
  input wire logic [7:0]        port_a_drive // port a out value
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // access classes
  wire logic port_op = acc.valid && (acc.op == iom_pkg::OP_PORT_LOAD ||
                                     acc.op == iom_pkg::OP_PORT_STORE);
  wire logic bit_op  = acc.valid && (acc.op == iom_pkg::OP_BIT_SET ||
                                     acc.op == iom_pkg::OP_BIT_CLEAR);
  wire logic mem_op  = acc.valid && (acc.op == iom_pkg::OP_MEM_READ ||
                                     acc.op == iom_pkg::OP_MEM_WRITE);

  property p_answer;
    acc.valid |=> rsp.done;
  endproperty
  property p_quiet;
    !acc.valid |=> !rsp.done && !wr_notice.valid;
  endproperty
  property p_bset;
    acc.valid && acc.op == iom_pkg::OP_BIT_SET && acc.addr == 8'h02
      |=> port_a_drive == ($past(port_a_drive) | (8'h01 << $past(acc.bit_sel)));
  endproperty
  property p_bhigh;
    bit_op && acc.addr > 8'h1F |=> rsp.refused && !wr_notice.valid;
  endproperty
  property p_portwin;
    port_op |=> rsp.refused == ($past(acc.addr) > 8'h3F);
  endproperty
  property p_ext;
    mem_op && acc.addr >= 8'h60 |=> !rsp.refused;
  endproperty
  property p_offset;
    acc.valid && acc.op == iom_pkg::OP_PORT_STORE && acc.addr <= 8'h3F
      |=> wr_notice.valid && wr_notice.addr == $past(acc.addr) + 8'h20;
  endproperty
  property p_skip;
    acc.valid && acc.op == iom_pkg::OP_SKIP_ONE && acc.addr == 8'h00
      |=> rsp.skip == $past(pin_a_level[acc.bit_sel]);
  endproperty
  property p_resv;
    acc.valid && acc.op == iom_pkg::OP_MEM_READ && (acc.addr == 8'h26 || acc.addr >= 8'hF9)
      |=> rsp.rdata == 8'h00;
  endproperty

  a_answer: assert property (p_answer) else $error("access not answered next cycle");
  a_quiet: assert property (p_quiet) else $error("answer without access");
  a_bset: assert property (p_bset) else $error("bit set result wrong");
  a_bhigh: assert property (p_bhigh) else $error("bit op above 1F taken");
  a_portwin: assert property (p_portwin) else $error("port window wrong");
  a_ext: assert property (p_ext) else $error("extended mem access refused");
  a_offset: assert property (p_offset) else $error("data address offset wrong");
  a_skip: assert property (p_skip) else $error("skip result wrong");
  a_resv: assert property (p_resv) else $error("reserved read not zero");

  c_skip: cover property (rsp.skip);
  c_refused: cover property (rsp.refused);
  c_flags: cover property (wr_notice.valid && wr_notice.addr == 8'h35);
endmodule

bind iom_io_map iom_io_map_chk i_iom_io_map_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .acc(acc), .rsp(rsp), .wr_notice(wr_notice),
  .pin_a_level(pin_a_level), .port_a_drive(port_a_drive));

`default_nettype wire

// File: test/tb_iom_io_map.sv
`timescale 1ns/10ps
`default_nettype none

module tb_iom_io_map;
  localparam iom_pkg::iom_op_t PL = iom_pkg::OP_PORT_LOAD;
  localparam iom_pkg::iom_op_t PS = iom_pkg::OP_PORT_STORE;
  localparam iom_pkg::iom_op_t BS = iom_pkg::OP_BIT_SET;
  localparam iom_pkg::iom_op_t BC = iom_pkg::OP_BIT_CLEAR;
  localparam iom_pkg::iom_op_t S1 = iom_pkg::OP_SKIP_ONE;
  localparam iom_pkg::iom_op_t S0 = iom_pkg::OP_SKIP_ZERO;
  localparam iom_pkg::iom_op_t RD = iom_pkg::OP_MEM_READ;
  localparam iom_pkg::iom_op_t WR = iom_pkg::OP_MEM_WRITE;

  logic              clk_sys = 1'b0;
  logic              reset_n = 1'b0;
  iom_pkg::iom_acc_t acc;
  iom_pkg::iom_rsp_t rsp;
  iom_pkg::iom_rsp_t r;
  iom_pkg::iom_wr_t  wr_notice;
  logic [7:0]        pin_a_level = 8'h00;
  logic [7:0]        pin_b_level = 8'h00;
  logic [1:0]        pin_d_level = 2'h0;
  logic [11:0]       conv_result = 12'h000;
  logic [2:0]        timer0_event = 3'h0;
  logic [1:0]        timer1_event = 2'h0;
  logic [1:0]        pin_change_event = 2'h0;
  logic [7:0]        port_a_drive, port_a_oe, port_b_drive, port_b_oe;
  logic              port_c_oe;
  logic [1:0]        port_d_drive, port_d_oe;
  int                num_errors = 0;
  int                n_tests = 0;
  // writable registers and the bits they hold
  logic [7:0] ra [8] = '{8'h21, 8'h28, 8'h2A, 8'h4B, 8'h64, 8'h68, 8'h6E, 8'h7C};
  logic [7:0] rm [8] = '{8'hFF, 8'h01, 8'h03, 8'hFF, 8'h0F, 8'h03, 8'h07, 8'h0F};

  always #4 clk_sys = ~clk_sys;

  iom_io_map i_iom_io_map (
    .clk_sys(clk_sys), .reset_n(reset_n), .acc(acc), .rsp(rsp), .wr_notice(wr_notice),
    .pin_a_level(pin_a_level), .pin_b_level(pin_b_level), .pin_d_level(pin_d_level),
    .conv_result(conv_result), .timer0_event(timer0_event), .timer1_event(timer1_event),
    .pin_change_event(pin_change_event), .port_a_drive(port_a_drive), .port_a_oe(port_a_oe),
    .port_b_drive(port_b_drive), .port_b_oe(port_b_oe), .port_c_oe(port_c_oe),
    .port_d_drive(port_d_drive), .port_d_oe(port_d_oe));

  iom_core_model i_iom_core_model (.clk_sys(clk_sys), .acc(acc), .rsp(rsp));

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one access; the refusal flag and the read byte are checked together
  task automatic t(input iom_pkg::iom_op_t op, input logic [7:0] a, input logic [2:0] b,
                   input logic [7:0] d, input logic rf, input logic [7:0] rd);
    logic ok;
    i_iom_core_model.go(op, a, b, d, r, ok);
    if (!ok) begin
      num_errors++;
      $display("ERROR %0t access not answered", $time);
      end_of_test();
    end
    cmp({r.refused, r.rdata}, {rf, rd});
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    // reset value, write all ones, read back only the named bits
    for (int i = 0; i < 8; i++) begin
      t(RD, ra[i], 3'h0, 8'h00, 1'b0, 8'h00);
      t(WR, ra[i], 3'h0, 8'hFF, 1'b0, 8'h00);
      t(RD, ra[i], 3'h0, 8'h00, 1'b0, rm[i]);
    end
    cmp({1'b0, port_a_oe}, 9'h0FF);
    cmp({5'h00, port_c_oe, port_d_oe, 1'b0}, 9'h00E);
    // port window and data-space offset
    t(PS, 8'h02, 3'h0, 8'h55, 1'b0, 8'h00);
    cmp({1'b0, port_a_drive}, 9'h055);
    t(RD, 8'h22, 3'h0, 8'h00, 1'b0, 8'h55);
    t(PL, 8'h02, 3'h0, 8'h00, 1'b0, 8'h55);
    t(PS, 8'h3F, 3'h0, 8'hAA, 1'b0, 8'h00);
    t(RD, 8'h5F, 3'h0, 8'h00, 1'b0, 8'hAA);
    t(PL, 8'h40, 3'h0, 8'h00, 1'b1, 8'h00);
    t(PS, 8'h6E, 3'h0, 8'h00, 1'b1, 8'h00);
    t(RD, 8'h6E, 3'h0, 8'h00, 1'b0, 8'h07);
    t(RD, 8'h1F, 3'h0, 8'h00, 1'b1, 8'h00);
    t(PS, 8'h0B, 3'h0, 8'h02, 1'b0, 8'h00);
    cmp({7'h00, port_d_drive}, 9'h002);
    // single-bit set and clear, low range only
    t(BS, 8'h02, 3'h7, 8'h00, 1'b0, 8'h00);
    t(BC, 8'h02, 3'h0, 8'h00, 1'b0, 8'h00);
    cmp({1'b0, port_a_drive}, 9'h0D4);
    t(BS, 8'h1F, 3'h4, 8'h00, 1'b0, 8'h00);
    t(RD, 8'h3F, 3'h0, 8'h00, 1'b0, 8'h10);
    t(BS, 8'h20, 3'h0, 8'h00, 1'b1, 8'h00);
    t(RD, 8'h40, 3'h0, 8'h00, 1'b0, 8'h00);
    // skip tests on a live pin byte
    @(posedge clk_sys);
    pin_a_level <= 8'h08;
    pin_b_level <= 8'h3C;
    pin_d_level <= 2'h2;
    conv_result <= 12'hABC;
    t(S1, 8'h00, 3'h3, 8'h00, 1'b0, 8'h00);
    cmp({8'h00, r.skip}, 9'h001);
    t(S0, 8'h00, 3'h3, 8'h00, 1'b0, 8'h00);
    cmp({8'h00, r.skip}, 9'h000);
    t(S0, 8'h00, 3'h2, 8'h00, 1'b0, 8'h00);
    cmp({8'h00, r.skip}, 9'h001);
    t(S1, 8'h20, 3'h0, 8'h00, 1'b1, 8'h00);
    cmp({8'h00, r.skip}, 9'h000);
    // read-only and reserved places keep their contents
    t(WR, 8'h23, 3'h0, 8'hFF, 1'b0, 8'h00);
    t(RD, 8'h23, 3'h0, 8'h00, 1'b0, 8'h3C);
    t(PL, 8'h09, 3'h0, 8'h00, 1'b0, 8'h02);
    t(RD, 8'h78, 3'h0, 8'h00, 1'b0, 8'hBC);
    t(RD, 8'h79, 3'h0, 8'h00, 1'b0, 8'h0A);
    t(WR, 8'h26, 3'h0, 8'hFF, 1'b0, 8'h00);
    t(RD, 8'h26, 3'h0, 8'h00, 1'b0, 8'h00);
    t(WR, 8'hFF, 3'h0, 8'h5A, 1'b0, 8'h00);
    t(RD, 8'hFF, 3'h0, 8'h00, 1'b0, 8'h00);
    // status flags: set by events, cleared only by written ones
    @(posedge clk_sys);
    timer0_event <= 3'h7;
    timer1_event <= 2'h3;
    pin_change_event <= 2'h3;
    @(posedge clk_sys);
    timer0_event <= 3'h0;
    timer1_event <= 2'h0;
    pin_change_event <= 2'h0;
    t(RD, 8'h35, 3'h0, 8'h00, 1'b0, 8'h07);
    t(WR, 8'h35, 3'h0, 8'h00, 1'b0, 8'h00);
    t(RD, 8'h35, 3'h0, 8'h00, 1'b0, 8'h07);
    t(WR, 8'h36, 3'h0, 8'h01, 1'b0, 8'h00);
    t(RD, 8'h36, 3'h0, 8'h00, 1'b0, 8'h02);
    t(BC, 8'h15, 3'h0, 8'h00, 1'b0, 8'h00);
    t(RD, 8'h35, 3'h0, 8'h00, 1'b0, 8'h01);
    // an event in the clearing cycle keeps its flag
    fork
      t(WR, 8'h35, 3'h0, 8'h01, 1'b0, 8'h00);
      begin
        @(posedge clk_sys);
        timer0_event <= 3'h1;
        @(posedge clk_sys);
        timer0_event <= 3'h0;
      end
    join
    t(RD, 8'h35, 3'h0, 8'h00, 1'b0, 8'h01);
    t(WR, 8'h35, 3'h0, 8'h01, 1'b0, 8'h00);
    t(RD, 8'h35, 3'h0, 8'h00, 1'b0, 8'h00);
    t(BS, 8'h1B, 3'h0, 8'h00, 1'b0, 8'h00);
    t(RD, 8'h3B, 3'h0, 8'h00, 1'b0, 8'h00);
    end_of_test();
  end
endmodule

`default_nettype wire
